// File: cisc_cfg.svh
/*
 * constants for the instruction subset core slice: opcode fields, flag reset
 * values and the instruction-cycle phase count.
 * assumes inclusion once per compile unit; the guard tolerates repeats.
 */
`ifndef CISC_CFG_SVH
`define CISC_CFG_SVH
`define CISC_OP_ADDK 8'hB1
`define CISC_OP_RETK 8'hB6
`define CISC_OP_RETI 16'h0005
`define CISC_OP_SLEEP 16'h0003
`define CISC_PHASES 4
`define CISC_PD_RST 1'b1
`define CISC_TO_RST 1'b1
`define CISC_GID_RST 1'b1
`define CISC_WDT_W 8
`endif

// File: cisc_clkout.sv
/*
 * divide-by-four clock output generator for the clock_out_pin.
 * assumes core_clk is the oscillator input clock itself.
 */
`timescale 1ns/1ps
`include "cisc_cfg.svh"
module cisc_clkout (
    input wire logic core_clk, // oscillator clock
    input wire logic rst_n, // sync reset
    input wire logic run, // oscillator running
    input wire cisc_pkg::cisc_oscmode_t mode, // oscillator mode
    output logic [1:0] phase, // quarter-cycle phase
    output logic clockOutPin, // divided clock
    output logic clockOutEn // pin driven
);
    import cisc_pkg::*;
    logic [1:0] next_phase;
    assign next_phase = run ? phase + 2'h1 : phase; // halted oscillator freezes phase
    // counter frozen while asleep, so the pin stops with the oscillator
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            phase <= 2'h0;
            clockOutPin <= 1'b0;
        end else begin
            phase <= next_phase;
            clockOutPin <= next_phase[1];
        end
    end
    assign clockOutEn = (mode == CISC_EXTCLK) || (mode == CISC_RCOSC);
    // the two edges after a reset release still see the held pin level two samples back, so skip them
    a_clkout_period: assert property (@(posedge core_clk) disable iff (!rst_n)
        $past(rst_n, 2) && $past(run) && run && $past(run, 2) && $past(run, 3)
        |-> clockOutPin == $past(clockOutPin, 2) ^ 1'b1)
        else $error("clock output period wrong");
endmodule : cisc_clkout

// File: cisc_core.sv
/*
 * execution slice of an 8-bit core: add-literal, return-with-constant,
 * return-from-irq and sleep, plus the divided clock output.
 * assumes instructions are presented on instr and sampled at the last phase
 * of each instruction cycle except a return's forced no-op; the stack and fetch logic live outside.
 */
`timescale 1ns/1ps
`include "cisc_cfg.svh"
module cisc_core #(
    parameter int WDT_W = `CISC_WDT_W
) (
    input wire logic core_clk, // oscillator input clock
    input wire logic rst_n, // sync reset, active low
    input wire cisc_pkg::cisc_oscmode_t oscMode, // oscillator mode strap
    input wire logic [15:0] instr, // current instruction word
    input wire logic [15:0] stackTop, // stack_top value
    input wire logic wakeWdt, // watchdog wake-up pin event
    input wire logic wakeOther, // other wake-up event
    output logic clockOutPin, // clock_out_pin level
    output logic clockOutEn, // clock_out_pin output enable
    output logic [7:0] workingRegister, // working register
    output logic [15:0] pc, // program counter
    output logic [7:0] pcHighHoldingLatch, // pc_high_holding_latch
    output logic flagOv, // overflow
    output logic flagC, // carry
    output logic flagDc, // digit carry
    output logic flagZ, // zero
    output logic powerDownFlag, // power_down_flag, active low meaning
    output logic timeOutFlag, // time_out_flag, active low meaning
    output logic globalIrqDisable, // global_irq_disable
    output logic [WDT_W-1:0] wdtCount, // watchdog count
    output logic stackPop, // one-cycle pop request
    output logic cycleEnd, // last phase of an instruction cycle, not raised in a return's forced no-op cycle
    output logic asleep // low-power state
);
    import cisc_pkg::*;
    cisc_state_t state, next_state;
    logic [1:0] phase;
    logic wdtS1, wdtS2, othS1, othS2;
    logic [8:0] sum;
    logic [4:0] lowSum;
    wire [7:0] lit = instr[7:0];
    wire isAddk = instr[15:8] == `CISC_OP_ADDK;
    wire isRetk = instr[15:8] == `CISC_OP_RETK;
    wire isReti = instr == `CISC_OP_RETI;
    wire isSleep = instr == `CISC_OP_SLEEP;
    wire running = state != CISC_SLEEP;
    wire exec = (state == CISC_RUN) && (phase == 2'(`CISC_PHASES - 1));
    wire wake = wdtS2 || othS2;

    cisc_clkout cisc_clkout_inst (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .run(running),
        .mode(oscMode),
        .phase(phase),
        .clockOutPin(clockOutPin),
        .clockOutEn(clockOutEn)
    );

    // wake-up events come from pins, so synchronise before use
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wdtS1 <= 1'b0;
            wdtS2 <= 1'b0;
            othS1 <= 1'b0;
            othS2 <= 1'b0;
        end else begin
            wdtS1 <= wakeWdt;
            wdtS2 <= wdtS1;
            othS1 <= wakeOther;
            othS2 <= othS1;
        end
    end

    // adder with nibble carry for digit carry
    assign sum = {1'b0, workingRegister} + {1'b0, lit};
    assign lowSum = {1'b0, workingRegister[3:0]} + {1'b0, lit[3:0]};
    assign cycleEnd = exec;
    assign asleep = state == CISC_SLEEP;
    assign stackPop = exec && (isRetk || isReti);

    // returns spend a second, forced no-op cycle; sleep holds until wake
    always_comb begin
        next_state = state;
        unique case (state)
            CISC_RUN: begin
                if (exec && (isRetk || isReti)) next_state = CISC_FNOP;
                else if (exec && isSleep) next_state = CISC_SLEEP;
            end
            CISC_FNOP: begin
                if (phase == 2'(`CISC_PHASES - 1)) next_state = CISC_RUN;
            end
            CISC_SLEEP: begin
                if (wake) next_state = CISC_RUN;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) state <= CISC_RUN;
        else state <= next_state;
    end

    // working register and arithmetic flags
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            workingRegister <= 8'h00;
            {flagOv, flagC, flagDc, flagZ} <= 4'h0;
        end else if (exec && isAddk) begin
            workingRegister <= sum[7:0];
            flagC <= sum[8];
            flagDc <= lowSum[4];
            flagZ <= sum[7:0] == 8'h00;
            flagOv <= (workingRegister[7] == lit[7]) && (sum[7] != lit[7]);
        end else if (exec && isRetk) begin
            workingRegister <= lit;
        end
    end

    // program counter; plain instructions just step, returns take the stack top
    always_ff @(posedge core_clk) begin
        if (!rst_n) pc <= 16'h0000;
        else if (exec && (isRetk || isReti)) pc <= stackTop;
        else if (exec) pc <= pc + 16'h0001;
    end

    // holding latch is never written by this slice
    always_ff @(posedge core_clk) begin
        if (!rst_n) pcHighHoldingLatch <= 8'h00;
        else pcHighHoldingLatch <= pcHighHoldingLatch;
    end

    // status flags, watchdog and irq disable
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            powerDownFlag <= `CISC_PD_RST;
            timeOutFlag <= `CISC_TO_RST;
            globalIrqDisable <= `CISC_GID_RST;
            wdtCount <= '0;
        end else begin
            if (exec && isSleep) begin
                powerDownFlag <= 1'b0;
                timeOutFlag <= 1'b1;
                wdtCount <= '0;
            end else if (running) begin
                wdtCount <= wdtCount + 1'b1;
            end
            if (state == CISC_SLEEP && wdtS2) timeOutFlag <= 1'b0;
            if (exec && isReti) globalIrqDisable <= 1'b0;
        end
    end

    sequence s_ret;
        exec && (isRetk || isReti);
    endsequence
    a_ret_pc: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_ret |=> pc == $past(stackTop)) else $error("return pc not loaded");
    a_retk_w: assert property (@(posedge core_clk) disable iff (!rst_n)
        exec && isRetk |=> workingRegister == $past(lit)) else $error("constant not loaded");
    a_latch_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_ret |=> $stable(pcHighHoldingLatch)) else $error("latch changed");
    a_addk_sum: assert property (@(posedge core_clk) disable iff (!rst_n)
        exec && isAddk |=> workingRegister == 8'($past(workingRegister) + $past(lit)))
        else $error("add result wrong");
    a_sleep_flags: assert property (@(posedge core_clk) disable iff (!rst_n)
        exec && isSleep |=> !powerDownFlag && timeOutFlag && wdtCount == '0 && asleep)
        else $error("sleep flags wrong");
    a_sleep_halt: assert property (@(posedge core_clk) disable iff (!rst_n)
        asleep && !wake |=> asleep && $stable(pc)) else $error("ran while asleep");
    a_wdt_wake: assert property (@(posedge core_clk) disable iff (!rst_n)
        asleep && wdtS2 |=> !timeOutFlag) else $error("time-out not cleared");
    a_reti_gie: assert property (@(posedge core_clk) disable iff (!rst_n)
        exec && isReti |=> !globalIrqDisable ##0 state == CISC_FNOP [*4] ##1 state == CISC_RUN)
        else $error("return from irq wrong");
    a_one_cycle: assert property (@(posedge core_clk) disable iff (!rst_n)
        exec && isAddk |=> state == CISC_RUN) else $error("add took extra cycle");
endmodule : cisc_core

// File: cisc_core_test.sv
/*
 * self-checking bench for cisc_core: a table of literal and return
 * instructions, then reset, clock output, sleep and wake cases.
 * assumes cisc_cfg.svh and cisc_pkg are compiled before this file.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module cisc_core_test;
    import cisc_pkg::*;
    typedef struct packed {
        logic [15:0] op;
        logic [15:0] top;
        logic [7:0] w;
        logic [3:0] fl;
        logic gid;
    } cisc_row_t;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    cisc_oscmode_t oscMode = CISC_EXTCLK;
    logic [15:0] instr = 16'h0000;
    logic [15:0] stackTop = 16'h0000;
    logic wakeWdt = 1'b0;
    logic wakeOther = 1'b0;
    logic clockOutPin, clockOutEn, flagOv, flagC, flagDc, flagZ, powerDownFlag, timeOutFlag;
    logic globalIrqDisable, stackPop, cycleEnd, asleep, popSeen, isRet, wasRet, snapClk;
    logic [7:0] workingRegister, pcHighHoldingLatch, wdtCount;
    logic [15:0] pc, expPc, snapPc;
    logic cp [0:7];
    int bad_count = 0;
    int n_tests = 0;
    int clkCnt = 0;
    int endAt, prevEnd, n;
    // flags column is {overflow, carry, digit carry, zero}
    cisc_row_t rows [0:7] = '{'{16'hB105, 16'h0000, 8'h05, 4'h0, 1'b1}, '{16'hB17B, 16'h0000, 8'h80, 4'hA, 1'b1},
        '{16'hB180, 16'h0000, 8'h00, 4'hD, 1'b1}, '{16'hB1FF, 16'h0000, 8'hFF, 4'h0, 1'b1},
        '{16'hB101, 16'h0000, 8'h00, 4'h7, 1'b1}, '{16'hB60F, 16'h1234, 8'h0F, 4'h7, 1'b1},
        '{16'hB10F, 16'h0000, 8'h1E, 4'h2, 1'b1}, '{16'h0005, 16'h0ABC, 8'h1E, 4'h2, 1'b0}};

    cisc_core #(.WDT_W(8)) cisc_core_inst (.core_clk(core_clk), .rst_n(rst_n), .oscMode(oscMode), .instr(instr),
        .stackTop(stackTop), .wakeWdt(wakeWdt), .wakeOther(wakeOther), .clockOutPin(clockOutPin),
        .clockOutEn(clockOutEn), .workingRegister(workingRegister), .pc(pc), .pcHighHoldingLatch(pcHighHoldingLatch),
        .flagOv(flagOv), .flagC(flagC), .flagDc(flagDc), .flagZ(flagZ), .powerDownFlag(powerDownFlag),
        .timeOutFlag(timeOutFlag), .globalIrqDisable(globalIrqDisable), .wdtCount(wdtCount), .stackPop(stackPop),
        .cycleEnd(cycleEnd), .asleep(asleep));

    initial begin
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        clkCnt <= clkCnt + 1;
    end

    task automatic print_verdict();
        if (bad_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    // mode only changes under reset, since the strap is static
    task automatic do_reset(input cisc_oscmode_t m);
        @(posedge core_clk);
        rst_n <= 1'b0;
        oscMode <= m;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        @(negedge core_clk);
        `CHK("rstW", 8'h00, workingRegister)
        `CHK("rstFlags", 3'b111, {powerDownFlag, timeOutFlag, globalIrqDisable})
    endtask : do_reset

    // word goes to a NOP after its executing edge so it never runs twice
    task automatic exec(input logic [15:0] w, input logic [15:0] t);
        n = 0;
        @(posedge core_clk);
        instr <= w;
        stackTop <= t;
        do begin
            @(negedge core_clk);
            n++;
        end while (cycleEnd !== 1'b1 && n < 40);
        if (n >= 40) begin
            bad_count++;
            print_verdict();
        end
        popSeen = stackPop;
        endAt = clkCnt;
        @(posedge core_clk);
        instr <= 16'h0000;
        @(negedge core_clk);
    endtask : exec

    initial begin
        do_reset(CISC_EXTCLK);
        expPc = 16'h0000;
        wasRet = 1'b0;
        prevEnd = 0;
        for (int i = 0; i < 8; i++) begin
            exec(rows[i].op, rows[i].top);
            isRet = rows[i].op[15:8] == 8'hB6 || rows[i].op == 16'h0005;
            expPc = isRet ? rows[i].top : expPc + 16'h0001;
            `CHK("w", rows[i].w, workingRegister)
            `CHK("flags", rows[i].fl, {flagOv, flagC, flagDc, flagZ})
            `CHK("pc", expPc, pc)
            `CHK("pop", isRet, popSeen)
            `CHK("latch", 8'h00, pcHighHoldingLatch)
            `CHK("gid", rows[i].gid, globalIrqDisable)
            if (i > 0) `CHK("spacing", wasRet ? 8 : 4, endAt - prevEnd)
            prevEnd = endAt;
            wasRet = isRet;
        end
        // crystal first, so the later sleep runs with the pin enabled
        for (int m = 2; m >= 0; m--) begin
            do_reset(cisc_oscmode_t'(m[1:0]));
            for (int j = 0; j < 8; j++) begin
                @(negedge core_clk);
                cp[j] = clockOutPin;
            end
            `CHK("clkEn", m != 2, clockOutEn)
            for (int j = 2; j < 8; j++) begin
                if (m != 2) `CHK("clkPer", ~cp[j - 2], cp[j])
            end
        end
        for (int s = 0; s < 2; s++) begin
            exec(16'h0003, 16'h0000);
            `CHK("asleep", 1'b1, asleep)
            `CHK("sleepFlags", 2'b01, {powerDownFlag, timeOutFlag})
            `CHK("wdt", 8'h00, wdtCount)
            snapPc = pc;
            snapClk = clockOutPin;
            repeat (6) @(negedge core_clk);
            `CHK("frozen", {snapPc, snapClk, 1'b1}, {pc, clockOutPin, asleep})
            @(posedge core_clk);
            wakeWdt <= (s == 0);
            wakeOther <= (s == 1);
            n = 0;
            do begin
                @(negedge core_clk);
                n++;
            end while (asleep !== 1'b0 && n < 10);
            `CHK("woke", 1'b0, asleep)
            @(posedge core_clk);
            wakeWdt <= 1'b0;
            wakeOther <= 1'b0;
            @(negedge core_clk);
            `CHK("toWake", s == 1, timeOutFlag)
        end
        print_verdict();
    end
endmodule : cisc_core_test

// File: cisc_pkg.sv
/*
 * types for the instruction subset core slice.
 * assumes cisc_cfg.svh is reachable by bare name.
 */
package cisc_pkg;
    typedef enum logic [1:0] {
        CISC_EXTCLK = 2'h0, // external_clock_mode
        CISC_RCOSC = 2'h1, // resistor_capacitor_osc_mode
        CISC_XTAL = 2'h2 // crystal modes, no clock output
    } cisc_oscmode_t;
    typedef enum logic [2:0] {
        CISC_RUN = 3'b001,
        CISC_FNOP = 3'b010,
        CISC_SLEEP = 3'b100
    } cisc_state_t;
endpackage : cisc_pkg
